// *** include/wwd_pkg.sv ***
// Constants, types and helpers shared by the window watchdog files.
package wwd_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses on the Wishbone bus)
	// ----------------------------------------------------------------
	localparam logic [7:0] WWD_CTL_ADR = 8'h00;
	localparam logic [7:0] WWD_WIN_ADR = 8'h04;
	localparam logic [7:0] WWD_STAT_ADR = 8'h08;
	localparam logic [7:0] WWD_OPT_ADR = 8'h0c;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int WWD_ACT_BIT = 7;
	localparam int WWD_TOP_BIT = 6;
	localparam int WWD_OPT_HW_BIT = 0;
	localparam int WWD_OPT_HALT_BIT = 1;
	localparam int WWD_OPT_TB_LO = 2;
	localparam int WWD_STAT_ACT_BIT = 0;
	localparam int WWD_STAT_HALT_BIT = 1;
	localparam logic [6:0] WWD_CNT_RESET = 7'h7f;
	localparam logic [6:0] WWD_WIN_RESET = 7'h7f;
	localparam logic [6:0] WWD_EXPIRE_VAL = 7'h40;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int WWD_PRESCALE_TICKS = 16384;
	localparam int WWD_PRE_W = 14;
	localparam int WWD_CLK_PERIOD_NS = 50;
	localparam int WWD_RST_PULSE_NS = 30000;
	localparam logic [9:0] WWD_RST_PULSE_CYC = 10'(WWD_RST_PULSE_NS / WWD_CLK_PERIOD_NS);

	// Timebase dependent offset of the prescaler phase.
	localparam logic [6:0] WWD_TB_LSB_2MS = 7'h3b;
	localparam logic [6:0] WWD_TB_LSB_4MS = 7'h35;
	localparam logic [6:0] WWD_TB_LSB_10MS = 7'h23;
	localparam logic [6:0] WWD_TB_LSB_25MS = 7'h36;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] timebase_select;
		logic halt_reset_option;
		logic hw_option;
	} wwd_opt_type;

	typedef enum logic [1:0] {
		WWD_RUN = 2'b00,
		WWD_HALT_STEP = 2'b01,
		WWD_HALT_STOP = 2'b11
	} wwd_state_type;

	// Prescaler count at which the downcounter steps: (LSB + 128) * 64 - 1.
	function automatic logic [WWD_PRE_W-1:0] wwd_tb_phase(input logic [1:0] tb);
		logic [6:0] lsb;
		lsb = WWD_TB_LSB_2MS;
		case (tb)
			2'b01: lsb = WWD_TB_LSB_4MS;
			2'b10: lsb = WWD_TB_LSB_10MS;
			2'b11: lsb = WWD_TB_LSB_25MS;
			default: lsb = WWD_TB_LSB_2MS;
		endcase
		return WWD_PRE_W'({1'b1, lsb, 6'h00} - 14'h0001);
	endfunction

endpackage

// *** hdl/wwd_prescaler.sv ***
// Free-running prescaler that turns secondary oscillator ticks into counter steps.
`timescale 1ns/1ps
module wwd_prescaler
	import wwd_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic tick_i,
	input wire logic [WWD_PRE_W-1:0] phase_i,
	output logic step_o
);

	logic [WWD_PRE_W-1:0] count;
	logic [WWD_PRE_W-1:0] next_count;
	logic step;
	wire hit = tick_i && (count == phase_i);

	// The count has no software load, so a counter reload never moves its phase.
	assign next_count = tick_i ? WWD_PRE_W'(count + 14'h0001) : count;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			count <= '0;
			step <= 1'b0;
		end
		else
		begin
			count <= next_count;
			step <= hit;
		end
	end

	assign step_o = step;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_step_spacing: assert property (step |=> !step)
		else $error("prescaler stepped on two cycles in a row");

endmodule

// *** hdl/wwd_top.sv ***
// Window watchdog with a Wishbone register slave.
`timescale 1ns/1ps
// Operation
// - Counter steps every 16384 oscillator ticks; writes never reset prescaler phase.
// - Six low counter bits give the step count before expiry.
// - Active watchdog resets when counter goes from 40h to 3Fh.
// - Watchdog reset drives the reset pin low about 30 microseconds.
// - Reloading an active watchdog while counter exceeds window limit causes a reset.
// - Software activation: off after reset, set bit enables until reset.
// - Hardware option keeps watchdog active, activation bit ignored.
// - Counter keeps counting down while watchdog disabled.
// - Writing activation set with top bit clear resets at once.
// - Active watchdog with halt option turns halt into a reset.
// - Timeout after a write varies with unknown prescaler phase.
// - Timebase select moves the step phase only; step period stays 16384 ticks.
// - Control and window registers reset to 7Fh.
// - Wait mode leaves the counter decrementing.
// - Halt without reset: one more step, then frozen, no reset.
module wwd_top
	import wwd_pkg::*;
(
	input wire logic MCLK_I,
	input wire logic RESETN_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic OSC_TICK_I,
	input wire logic HALT_REQ_I,
	input wire logic WAKE_I,
	output logic HALT_ENTER_O,
	output logic RESET_REQ_O,
	output logic RESET_PIN_N_O
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic act;
	logic [6:0] counter;
	logic [6:0] window;
	wwd_opt_type opt;
	wwd_state_type state;
	wwd_state_type next_state;
	logic [6:0] next_counter;
	logic ack;
	logic [31:0] rdata;
	logic req;
	logic halt_enter;
	logic [9:0] pin_cnt;
	logic [9:0] next_pin_cnt;
	logic pin_n;
	logic step;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire bus_req = WB_CYC_I && WB_STB_I;
	wire bus_wr = bus_req && WB_WE_I && ack && WB_SEL_I[0];
	wire sel_ctl = (WB_ADR_I == WWD_CTL_ADR);
	wire sel_win = (WB_ADR_I == WWD_WIN_ADR);
	wire sel_stat = (WB_ADR_I == WWD_STAT_ADR);
	wire sel_opt = (WB_ADR_I == WWD_OPT_ADR);
	wire wr_ctl = bus_wr && sel_ctl;
	wire wr_win = bus_wr && sel_win;
	wire wr_opt = bus_wr && sel_opt;
	wire [7:0] wdat = WB_DAT_I[7:0];

	wire active = act || opt.hw_option;

	logic [7:0] read_mux;
	always_comb
	begin
		read_mux = 8'h00;
		if (sel_ctl)
			read_mux = {act, counter};
		else if (sel_win)
			read_mux = {1'b0, window};
		else if (sel_stat)
			read_mux = {6'h00, state != WWD_RUN, active};
		else if (sel_opt)
			read_mux = {4'h0, opt};
	end

	// ----------------------------------------------------------------
	// Watchdog decisions
	// ----------------------------------------------------------------
	wire halted = (state != WWD_RUN);
	wire step_eff = step && (state != WWD_HALT_STOP);

	// Both halted states mask the timeout, so the one step taken in WWD_HALT_STEP cannot expire either.
	wire timeout = active && !halted && step_eff && !wr_ctl
		&& (counter == WWD_EXPIRE_VAL);
	wire win_err = wr_ctl && active && (counter > window);
	wire soft_rst = wr_ctl && (active || wdat[WWD_ACT_BIT])
		&& !wdat[WWD_TOP_BIT];
	wire halt_rst = HALT_REQ_I && active && opt.halt_reset_option;
	wire fire = timeout || win_err || soft_rst || halt_rst;

	// The counter runs whether or not the watchdog is active; wait mode has no input here.
	always_comb
	begin
		next_counter = counter;
		if (wr_ctl)
			next_counter = wdat[6:0];
		else if (step_eff)
			next_counter = 7'(counter - 7'h01);
	end

	always_comb
	begin
		next_state = state;
		case (state)
			WWD_RUN:
				if (HALT_REQ_I && !halt_rst)
					next_state = WWD_HALT_STEP;
			WWD_HALT_STEP:
				if (WAKE_I)
					next_state = WWD_RUN;
				else if (step)
					next_state = WWD_HALT_STOP;
			WWD_HALT_STOP:
				if (WAKE_I)
					next_state = WWD_RUN;
			default:
				next_state = WWD_RUN;
		endcase
	end

	assign next_pin_cnt = fire ? WWD_RST_PULSE_CYC
		: (pin_cnt != 10'h000) ? 10'(pin_cnt - 10'h001) : pin_cnt;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			act <= 1'b0;
			counter <= WWD_CNT_RESET;
			window <= WWD_WIN_RESET;
			state <= WWD_RUN;
		end
		else if (fire)
		begin
			// The watchdog's own reset returns act, counter, window and state to their power-on values.
			act <= 1'b0;
			counter <= WWD_CNT_RESET;
			window <= WWD_WIN_RESET;
			state <= WWD_RUN;
		end
		else
		begin
			act <= act || (wr_ctl && wdat[WWD_ACT_BIT]);
			counter <= next_counter;
			window <= wr_win ? wdat[6:0] : window;
			state <= next_state;
		end
	end

	// Options behave like an option byte: the watchdog's own reset keeps them.
	always_ff @(posedge MCLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			opt <= '0;
		else if (wr_opt)
			opt <= wdat[3:0];
	end

	always_ff @(posedge MCLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			ack <= 1'b0;
			rdata <= '0;
		end
		else
		begin
			ack <= bus_req && !ack;
			rdata <= {24'h000000, read_mux};
		end
	end

	always_ff @(posedge MCLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			req <= 1'b0;
			halt_enter <= 1'b0;
			pin_cnt <= 10'h000;
			pin_n <= 1'b1;
		end
		else
		begin
			req <= fire;
			halt_enter <= HALT_REQ_I && !halt_rst && !halted;
			pin_cnt <= next_pin_cnt;
			pin_n <= (next_pin_cnt == 10'h000);
		end
	end

	// ----------------------------------------------------------------
	// Prescaler
	// ----------------------------------------------------------------
	wwd_prescaler u_pre (
		.clk_i(MCLK_I),
		.rst_n_i(RESETN_I),
		.tick_i(OSC_TICK_I),
		.phase_i(wwd_tb_phase(opt.timebase_select)),
		.step_o(step)
	);

	assign WB_ACK_O = ack;
	assign WB_DAT_O = rdata;
	assign RESET_REQ_O = req;
	assign RESET_PIN_N_O = pin_n;
	assign HALT_ENTER_O = halt_enter;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RESETN_I);

	sequence s_expiry;
		active && !halted && step && !wr_ctl && counter == 7'h40;
	endsequence

	sequence s_bad_reload;
		wr_ctl && active && counter > window;
	endsequence

	a_expiry_reset: assert property (s_expiry |=> RESET_REQ_O && counter == 7'h7f)
		else $error("expiry at 40h gave no reset");

	a_window_reset: assert property (s_bad_reload |=> RESET_REQ_O)
		else $error("reload above window gave no reset");

	a_soft_reset: assert property (wr_ctl && wdat[7] && !wdat[6] |=> RESET_REQ_O)
		else $error("software reset write ignored");

	a_halt_reset: assert property (HALT_REQ_I && active && opt.halt_reset_option
		|=> RESET_REQ_O && !halted)
		else $error("halt with reset option did not reset");

	a_req_single: assert property (RESET_REQ_O |=> !RESET_REQ_O)
		else $error("reset request longer than one cycle");

	a_reset_value: assert property (RESET_REQ_O |-> counter == 7'h7f
		&& window == 7'h7f && !act)
		else $error("registers not back at 7Fh after reset");

	a_act_sticky: assert property ($fell(act) |-> RESET_REQ_O)
		else $error("activation cleared without a reset");

	a_hw_active: assert property (opt.hw_option && step && !halted && !wr_ctl
		&& counter == 7'h40 |=> RESET_REQ_O)
		else $error("hardware option expiry gave no reset");

	a_free_run: assert property (step && !halted && !wr_ctl && !fire
		|=> counter == $past(counter) - 7'h01)
		else $error("counter failed to step");

	a_pin_low: assert property (RESET_REQ_O |-> (!RESET_PIN_N_O)[*8])
		else $error("reset pin released too early");

	a_halt_freeze: assert property (state == WWD_HALT_STOP && !WAKE_I && !wr_ctl
		|=> counter == $past(counter) && !RESET_REQ_O)
		else $error("counter moved while halted");

endmodule

// *** sim/test_window_watchdog_timer.sv ***
// Self-checking testbench for the window watchdog with a small register model.
`timescale 1ns/1ps
module test_window_watchdog_timer
	import wwd_pkg::*;
;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0;
	logic [31:0] rdat;
	logic ack;
	logic halt = 1'b0;
	logic wake = 1'b0;
	logic enter;
	logic req;
	logic pin_n;
	logic [7:0] lfsr = 8'h34;
	logic [31:0] q;
	int miscompares = 0;
	int samples_checked = 0;
	int cycles = 0;
	int req_n = 0;
	int enter_n = 0;
	int pin_len = 0;
	int low_run = 0;
	int m_win = 'h7f;
	int m_act = 0;
	int m_hw = 0;
	int r;
	int n;

	initial forever #25 mclk = ~mclk;

	wwd_top dut (.MCLK_I(mclk), .RESETN_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat),
		.WB_ACK_O(ack), .OSC_TICK_I(1'b1), .HALT_REQ_I(halt), .WAKE_I(wake),
		.HALT_ENTER_O(enter), .RESET_REQ_O(req), .RESET_PIN_N_O(pin_n));

	// ----------------------------------------------------------------
	// Stimulus helpers
	// ----------------------------------------------------------------
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Output events are counted here so that checks never race the pulse edge.
	always @(posedge mclk)
	begin
		cycles++;
		if (req === 1'b1) req_n++;
		if (enter === 1'b1) enter_n++;
		if (pin_n === 1'b0) low_run++;
		else if (low_run > 0)
		begin
			pin_len = low_run;
			low_run = 0;
		end
		if (cycles == 90000)
		begin
			miscompares++;
			wrap_up();
		end
	end

	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int k;
		@(posedge mclk);
		lfsr = lfsr_next(lfsr);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= {lfsr[2:0], 1'b1};
		dat <= {lfsr, lfsr, lfsr, d};
		k = 0;
		@(posedge mclk);
		while (ack !== 1'b1 && k < 20)
		begin
			@(posedge mclk);
			k++;
		end
		if (k == 20) miscompares++;
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic model_reset();
		m_win = 'h7f;
		m_act = 0;
		pin_len = 0;
		repeat (610) @(posedge mclk);
		check("pin_low_cycles", pin_len, 600);
	endtask

	task automatic wr_ctl(input logic [7:0] d, input int cnt);
		bit rst;
		r = req_n;
		rst = ((m_act | m_hw) != 0 && cnt > m_win) || ((m_act | m_hw | d[7]) != 0 && !d[6]);
		bus(1'b1, WWD_CTL_ADR, d);
		repeat (3) @(posedge mclk);
		check("reset_req", req_n - r, 32'(rst));
		m_act = m_act | d[7];
		if (rst) model_reset();
	endtask

	task automatic halt_try(input bit rst);
		r = req_n;
		n = enter_n;
		@(posedge mclk);
		halt <= 1'b1;
		@(posedge mclk);
		halt <= 1'b0;
		repeat (3) @(posedge mclk);
		check("halt_reset", req_n - r, 32'(rst));
		check("halt_enter", enter_n - n, 32'(!rst));
		if (rst) model_reset();
		else
		begin
			bus(1'b0, WWD_STAT_ADR, 8'h00);
			check("status_halted", q, 32'(2 + (m_act | m_hw)));
			@(posedge mclk);
			wake <= 1'b1;
			@(posedge mclk);
			wake <= 1'b0;
		end
	endtask

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		bus(1'b0, WWD_CTL_ADR, 8'h00);
		check("ctl_reset", q, 32'h7f);
		bus(1'b0, WWD_WIN_ADR, 8'h00);
		check("win_reset", q, 32'h7f);
		bus(1'b0, WWD_STAT_ADR, 8'h00);
		check("status_reset", q, 32'h0);
		bus(1'b0, 8'h10, 8'h00);
		check("unmapped", q, 32'h0);
		$display("reset values test done");
		bus(1'b1, WWD_WIN_ADR, 8'h42);
		m_win = 'h42;
		wr_ctl(8'hc5, 'h7f);
		bus(1'b0, WWD_STAT_ADR, 8'h00);
		check("status_active", q, 32'h1);
		bus(1'b1, WWD_WIN_ADR, 8'h50);
		m_win = 'h50;
		wr_ctl(8'hc5, 'h45);
		bus(1'b1, WWD_WIN_ADR, 8'h42);
		m_win = 'h42;
		wr_ctl(8'hc5, 'h45);
		bus(1'b0, WWD_CTL_ADR, 8'h00);
		check("ctl_after_reset", q, 32'h7f);
		$display("window test done");
		wr_ctl(8'h00, 'h7f);
		wr_ctl(8'h80, 'h00);
		$display("software reset test done");
		bus(1'b1, WWD_OPT_ADR, 8'h02);
		halt_try(1'b0);
		wr_ctl(8'hc5, 'h7f);
		halt_try(1'b1);
		bus(1'b1, WWD_OPT_ADR, 8'h01);
		m_hw = 1;
		bus(1'b0, WWD_STAT_ADR, 8'h00);
		check("status_hw", q, 32'h1);
		wr_ctl(8'hc5, 'h7f);
		halt_try(1'b0);
		bus(1'b1, WWD_OPT_ADR, 8'h03);
		halt_try(1'b1);
		bus(1'b1, WWD_OPT_ADR, 8'h0c);
		m_hw = 0;
		bus(1'b0, WWD_OPT_ADR, 8'h00);
		check("opt_readback", q, 32'h0c);
		$display("halt and option test done");
		wr_ctl(8'h41, 'h7f);
		r = req_n;
		repeat (32800) @(posedge mclk);
		bus(1'b0, WWD_CTL_ADR, 8'h00);
		check("idle_reset", req_n - r, 0);
		check("count_down", 32'(q == 'h3f || q == 'h3e), 1);
		wr_ctl(8'hc1, 'h41);
		n = 0;
		while (req_n == r && n < 33000)
		begin
			@(posedge mclk);
			n++;
		end
		check("timeout_range", 32'(n >= 16380 && n <= 32772), 1);
		model_reset();
		$display("timeout test done");
		wrap_up();
	end
endmodule
